// ---- design/acr_pkg.sv ----
// register map, field positions, reset values and timing for the converter wrapper
// assumes a 32-bit APB master; only the low byte of each word carries data
package acr_pkg;
  // byte offsets of the APB words
  localparam logic [7:0] OFS_RES_LOW   = 8'h00;
  localparam logic [7:0] OFS_RES_HIGH  = 8'h04;
  localparam logic [7:0] OFS_CTRL_MAIN = 8'h08;
  localparam logic [7:0] OFS_CTRL_AUX  = 8'h0C;
  localparam logic [7:0] OFS_PIN_LOW   = 8'h10;
  localparam logic [7:0] OFS_PIN_HIGH  = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h1C;
  // converter_control_main fields
  localparam int BIT_START   = 7;
  localparam int BIT_BUSY    = 6;
  localparam int BIT_PWRDN   = 5;
  localparam int BIT_JUSTIFY = 4;
  localparam int BIT_CH3     = 3;
  // converter_control_aux fields
  localparam int BIT_INTREF  = 7;
  localparam int BIT_BANDGAP = 6;
  localparam int BIT_EXTREF  = 4;
  // interrupt status / mask field
  localparam int BIT_DONE    = 0;
  // values after reset
  localparam logic       RST_START   = 1'b0;
  localparam logic       RST_BUSY    = 1'b1;
  localparam logic       RST_PWRDN   = 1'b1;
  localparam logic [7:0] RST_AUX     = 8'h00;
  localparam logic [7:0] RST_PIN_LOW = 8'hFF;
  localparam logic [3:0] RST_PIN_HI  = 4'hF;
  // converter clocks from end of start to end of conversion
  localparam int CONV_CYCLES = 16;
  localparam int RES_BITS    = 12;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_CONV = 2'b10
  } acr_state_t;
endpackage : acr_pkg

// ---- design/acr_clk_div.sv ----
// converter clock prescaler: one-cycle tick every 2**code system clocks for codes 0 to 6; code 7 ticks every 64
// assumes clear is held while no conversion runs
`timescale 1ns/1ns
module acr_clk_div (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       ce,
  // control
  input  wire logic       clear,
  input  wire logic [2:0] div_code,
  // converter clock tick
  output logic            tick
);
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic [5:0] mask;

  always_comb begin
    // code 111 is undefined; it falls back to divide by 64
    if (div_code == 3'h7) begin
      mask = 6'h3F;
    end else begin
      mask = 6'((7'h01 << div_code) - 7'h01);
    end
    tick     = !clear && ((cnt & mask) == mask); // RULE_18
    next_cnt = clear ? 6'h00 : 6'(cnt + 6'h01);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 6'h00;
    end else if (ce) begin
      cnt <= next_cnt;
    end
  end
endmodule : acr_clk_div

// ---- design/acr_result_fmt.sv ----
// places the 12-bit result into the low and high result bytes
// assumes raw data is held stable by the caller
`timescale 1ns/1ns
module acr_result_fmt (
  // raw result and format
  input  wire logic [11:0] raw,
  input  wire logic        justify,
  // formatted bytes
  output logic [7:0]       low_byte,
  output logic [7:0]       high_byte
);
  always_comb begin
    if (justify) begin
      high_byte = {4'h0, raw[11:8]}; // RULE_03 RULE_04
      low_byte  = raw[7:0];          // RULE_03
    end else begin
      high_byte = raw[11:4];         // RULE_02
      low_byte  = {raw[3:0], 4'h0};  // RULE_02 RULE_04
    end
  end
endmodule : acr_result_fmt

// ---- design/acr_top.sv ----
// converter control and result registers behind an APB slave
// assumes the analog core converts while core_reset is low and presents
// its 12-bit value on core_result by the end of the conversion count
//
// What this block does
// RULE_01: each conversion yields a held 12-bit unsigned result
// RULE_02: format zero gives left justified result
// RULE_03: format one gives right justified result
// RULE_04: unused result bit positions read zero
// RULE_05: start rising then falling begins conversion
// RULE_06: start held high resets core, busy one
// RULE_07: busy flag high while converting, resets high
// RULE_08: power-down bit one switches core off, resets one
// RULE_09: software should power down before sleeping
// RULE_10: eight inputs: three-bit field picks channel
// RULE_11: twelve inputs: codes above eleven undefined
// RULE_12: internal reference select overrides channel field
// RULE_13: pin enable bit routes pin to converter
// RULE_14: analog pins lose digital function and pull-up
// RULE_15: eight-input variant: control bit three reads zero
// RULE_16: result holds completed value for reading
// RULE_17: conversion end clears busy, raises interrupt flag
// RULE_18: clock field divides system clock by 2**code; code 7 divides by 64 instead of 128
// RULE_19: conversion lasts a fixed count of converter clocks
`timescale 1ns/1ns
module acr_top #(
  parameter int NUM_CHANNELS = 12,
  parameter int CONV_CYCLES  = acr_pkg::CONV_CYCLES
) (
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // analog core
  input  wire logic [11:0] core_result,
  output logic             core_reset,
  output logic             core_power_down,
  output logic             core_clk_tick,
  output logic      [3:0]  mux_channel,
  output logic             mux_internal_ref,
  output logic             bandgap_en,
  output logic             ext_ref_sel,
  // shared pins
  input  wire logic [11:0] pin_pullup_req,
  output logic      [11:0] pin_analog_en,
  output logic      [11:0] pin_digital_en,
  output logic      [11:0] pin_pullup_en,
  // interrupt
  output logic             irq
);
  // ***************************************
  // elaboration checks
  // ***************************************
  if (NUM_CHANNELS != 8 && NUM_CHANNELS != 12) begin : g_bad_ch
    $error("NUM_CHANNELS must be 8 or 12");
  end
  if (CONV_CYCLES < 1 || CONV_CYCLES > 255) begin : g_bad_cyc
    $error("CONV_CYCLES must be 1 to 255");
  end

  localparam logic [7:0] LAST_CNT = 8'(CONV_CYCLES - 1);
  localparam logic [3:0] CH_MASK  = (NUM_CHANNELS == 12) ? 4'hF : 4'h7;

  // ***************************************
  // state
  // ***************************************
  acr_pkg::acr_state_t state, next_state;
  logic        start_bit, next_start_bit;
  logic        busy, next_busy;
  logic        pwrdn, next_pwrdn;
  logic        justify, next_justify;
  logic [3:0]  chan, next_chan;
  logic [7:0]  aux, next_aux;
  logic [11:0] pin_en, next_pin_en;
  logic [11:0] result, next_result;
  logic        stat_done, next_stat_done;
  logic        mask_done, next_mask_done;
  logic [7:0]  conv_cnt, next_conv_cnt;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        tick;
  logic [7:0]  fmt_low;
  logic [7:0]  fmt_high;
  logic        setup;
  logic        wr_done;
  logic        rd_done;
  logic        done_evt;

  // ***************************************
  // helpers
  // ***************************************
  acr_clk_div u_div (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .ce       (ce),
    .clear    (state != acr_pkg::ST_CONV),
    .div_code (aux[2:0]),
    .tick     (tick)
  );

  acr_result_fmt u_fmt (
    .raw       (result),
    .justify   (justify),
    .low_byte  (fmt_low),
    .high_byte (fmt_high)
  );

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == acr_pkg::OFS_RES_LOW)   || (a == acr_pkg::OFS_RES_HIGH) ||
             (a == acr_pkg::OFS_CTRL_MAIN) || (a == acr_pkg::OFS_CTRL_AUX) ||
             (a == acr_pkg::OFS_PIN_LOW)   || (a == acr_pkg::OFS_PIN_HIGH) ||
             (a == acr_pkg::OFS_IRQ_STAT)  || (a == acr_pkg::OFS_IRQ_MASK);
  endfunction : mapped

  // ***************************************
  // apb decode and register read
  // ***************************************
  always_comb begin
    setup   = psel && !penable;
    wr_done = psel && penable && pready && pwrite && !pslverr;
    rd_done = psel && penable && pready && !pwrite && !pslverr;
    next_pready  = setup;
    next_pslverr = setup && !mapped(paddr);
    next_prdata  = prdata;
    if (setup) begin
      next_prdata = 32'h0000_0000;
      if (pwrite) begin
        next_prdata = 32'h0000_0000;
      end else if (paddr == acr_pkg::OFS_RES_LOW) begin
        next_prdata[7:0] = fmt_low; // RULE_16
      end else if (paddr == acr_pkg::OFS_RES_HIGH) begin
        next_prdata[7:0] = fmt_high; // RULE_16
      end else if (paddr == acr_pkg::OFS_CTRL_MAIN) begin
        next_prdata[acr_pkg::BIT_START]   = start_bit;
        next_prdata[acr_pkg::BIT_BUSY]    = busy; // RULE_07
        next_prdata[acr_pkg::BIT_PWRDN]   = pwrdn;
        next_prdata[acr_pkg::BIT_JUSTIFY] = justify;
        next_prdata[3:0]                  = chan & CH_MASK; // RULE_15
      end else if (paddr == acr_pkg::OFS_CTRL_AUX) begin
        next_prdata[7:0] = aux & 8'hD7;
      end else if (paddr == acr_pkg::OFS_PIN_LOW) begin
        next_prdata[7:0] = pin_en[7:0];
      end else if (paddr == acr_pkg::OFS_PIN_HIGH) begin
        next_prdata[3:0] = pin_en[11:8];
      end else if (paddr == acr_pkg::OFS_IRQ_STAT) begin
        next_prdata[acr_pkg::BIT_DONE] = stat_done;
      end else if (paddr == acr_pkg::OFS_IRQ_MASK) begin
        next_prdata[acr_pkg::BIT_DONE] = mask_done;
      end
    end
  end

  // ***************************************
  // control registers and conversion sequence
  // ***************************************
  always_comb begin
    next_state     = state;
    next_start_bit = start_bit;
    next_busy      = busy;
    next_pwrdn     = pwrdn;
    next_justify   = justify;
    next_chan      = chan;
    next_aux       = aux;
    next_pin_en    = pin_en;
    next_result    = result;
    next_mask_done = mask_done;
    next_conv_cnt  = conv_cnt;
    done_evt       = 1'b0;
    if (wr_done) begin
      if (paddr == acr_pkg::OFS_CTRL_MAIN) begin
        next_start_bit = pwdata[acr_pkg::BIT_START];
        next_pwrdn     = pwdata[acr_pkg::BIT_PWRDN]; // RULE_08
        next_justify   = pwdata[acr_pkg::BIT_JUSTIFY];
        next_chan      = pwdata[3:0] & CH_MASK; // RULE_10 RULE_11 RULE_15
      end else if (paddr == acr_pkg::OFS_CTRL_AUX) begin
        next_aux = pwdata[7:0] & 8'hD7;
      end else if (paddr == acr_pkg::OFS_PIN_LOW) begin
        next_pin_en[7:0] = pwdata[7:0]; // RULE_13
      end else if (paddr == acr_pkg::OFS_PIN_HIGH && NUM_CHANNELS == 12) begin
        next_pin_en[11:8] = pwdata[3:0]; // RULE_13
      end else if (paddr == acr_pkg::OFS_IRQ_MASK) begin
        next_mask_done = pwdata[acr_pkg::BIT_DONE];
      end
    end
    case (state)
      acr_pkg::ST_IDLE: begin
        if (start_bit) begin
          next_state = acr_pkg::ST_HOLD;
          next_busy  = 1'b1; // RULE_06
        end
      end
      acr_pkg::ST_HOLD: begin
        next_busy = 1'b1; // RULE_06
        if (!start_bit) begin
          next_state    = acr_pkg::ST_CONV; // RULE_05
          next_conv_cnt = 8'h00;
        end
      end
      acr_pkg::ST_CONV: begin
        if (start_bit) begin
          next_state = acr_pkg::ST_HOLD; // RULE_06
        end else if (tick && !pwrdn) begin
          if (conv_cnt == LAST_CNT) begin
            next_state  = acr_pkg::ST_IDLE; // RULE_19
            next_busy   = 1'b0; // RULE_07 RULE_17
            next_result = core_result; // RULE_01
            done_evt    = 1'b1; // RULE_17
          end else begin
            next_conv_cnt = 8'(conv_cnt + 8'h01); // RULE_19
          end
        end
      end
      default: begin
        next_state = acr_pkg::ST_IDLE;
      end
    endcase
    // a read clears only what it returned; a new event wins
    next_stat_done = done_evt || (stat_done && !(rd_done &&
                     paddr == acr_pkg::OFS_IRQ_STAT && prdata[acr_pkg::BIT_DONE]));
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state     <= acr_pkg::ST_IDLE;
      start_bit <= acr_pkg::RST_START;
      busy      <= acr_pkg::RST_BUSY; // RULE_07
      pwrdn     <= acr_pkg::RST_PWRDN; // RULE_08
      justify   <= 1'b0;
      chan      <= 4'h0;
      aux       <= acr_pkg::RST_AUX;
      pin_en    <= {acr_pkg::RST_PIN_HI, acr_pkg::RST_PIN_LOW};
      result    <= 12'h000;
      stat_done <= 1'b0;
      mask_done <= 1'b0;
      conv_cnt  <= 8'h00;
      prdata    <= 32'h0000_0000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end else if (ce) begin
      state     <= next_state;
      start_bit <= next_start_bit;
      busy      <= next_busy;
      pwrdn     <= next_pwrdn;
      justify   <= next_justify;
      chan      <= next_chan;
      aux       <= next_aux;
      pin_en    <= next_pin_en & {(NUM_CHANNELS == 12) ? 4'hF : 4'h0, 8'hFF};
      result    <= next_result;
      stat_done <= next_stat_done;
      mask_done <= next_mask_done;
      conv_cnt  <= next_conv_cnt;
      prdata    <= next_prdata;
      pready    <= next_pready;
      pslverr   <= next_pslverr;
    end
  end

  // ***************************************
  // registered outputs to core and pins
  // ***************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      core_reset       <= 1'b0;
      core_power_down  <= acr_pkg::RST_PWRDN;
      core_clk_tick    <= 1'b0;
      mux_channel      <= 4'h0;
      mux_internal_ref <= 1'b0;
      bandgap_en       <= 1'b0;
      ext_ref_sel      <= 1'b0;
      pin_analog_en    <= 12'h000;
      pin_digital_en   <= 12'hFFF;
      pin_pullup_en    <= 12'h000;
      irq              <= 1'b0;
    end else if (ce) begin
      core_reset       <= next_start_bit; // RULE_06
      core_power_down  <= next_pwrdn; // RULE_08
      core_clk_tick    <= tick && (state == acr_pkg::ST_CONV);
      mux_channel      <= next_chan; // RULE_10 RULE_11
      mux_internal_ref <= next_aux[acr_pkg::BIT_INTREF]; // RULE_12
      bandgap_en       <= next_aux[acr_pkg::BIT_BANDGAP];
      ext_ref_sel      <= next_aux[acr_pkg::BIT_EXTREF];
      pin_analog_en    <= pin_en; // RULE_13
      pin_digital_en   <= ~pin_en; // RULE_14
      pin_pullup_en    <= pin_pullup_req & ~pin_en; // RULE_14
      irq              <= next_stat_done && next_mask_done; // RULE_17
    end
  end

  // ***************************************
  // assertions
  // ***************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n || !ce);

  sequence s_start_pulse;
    start_bit ##1 !start_bit;
  endsequence

  a_start_busy: assert property (start_bit |-> core_reset ##1 busy) // RULE_06
    else $error("start high without busy or core reset");
  a_start_fall: assert property (s_start_pulse |=> state == acr_pkg::ST_CONV) // RULE_05
    else $error("conversion did not begin after start pulse");
  a_busy_end: assert property ($fell(busy) |-> stat_done && !start_bit) // RULE_17
    else $error("busy cleared without done flag");
  a_result_hold: assert property (!done_evt |=> $stable(result)) // RULE_16
    else $error("result changed outside conversion end");
  a_fmt_left: assert property (!justify |-> fmt_high == result[11:4] && fmt_low == {result[3:0], 4'h0}) // RULE_02
    else $error("left justified format wrong");
  a_fmt_right: assert property (justify |-> fmt_high == {4'h0, result[11:8]} && fmt_low == result[7:0]) // RULE_03
    else $error("right justified format wrong");
  a_pin_pullup: assert property (1'b1 |=> pin_pullup_en == ($past(pin_pullup_req) & ~$past(pin_en))) // RULE_14
    else $error("pull-up not cut on analog pin");
  a_ref_route: assert property (aux[acr_pkg::BIT_INTREF] |-> mux_internal_ref) // RULE_12
    else $error("internal reference not routed");
  a_conv_len: assert property (done_evt |-> conv_cnt == LAST_CNT && tick) // RULE_19
    else $error("conversion length wrong");
  a_chan_bit3: assert property (NUM_CHANNELS == 8 |-> !chan[3]) // RULE_15
    else $error("bit three set in eight-input variant");

  sequence s_conv_end;
    state == acr_pkg::ST_CONV ##1 state == acr_pkg::ST_IDLE;
  endsequence

  a_end_flag: assert property (s_conv_end |-> stat_done && !busy) // RULE_17
    else $error("conversion end without done flag");
  a_busy_run: assert property (state != acr_pkg::ST_IDLE |-> busy) // RULE_07
    else $error("busy low while converting");
  a_irq_level: assert property (irq == (stat_done && mask_done)) // RULE_17
    else $error("irq does not follow unmasked status");
  a_pin_exclusive: assert property ((pin_analog_en & pin_digital_en) == 12'h000) // RULE_14
    else $error("pin both analog and digital");
  a_core_off: assert property (core_power_down == pwrdn) // RULE_08
    else $error("core power state differs from control bit");
  a_fmt_zero: assert property (justify ? fmt_high[7:4] == 4'h0 : fmt_low[3:0] == 4'h0) // RULE_04
    else $error("unused result bits not zero");
endmodule : acr_top

// ---- sim/acr_core_model.sv ----
// analog core stand-in: one level per input pin plus an internal reference
// assumes acr_top drives its core controls on ref_clk
`timescale 1ns/1ns
module acr_core_model #(
  parameter logic [11:0] REF_LEVEL = 12'h5D2
) (
  // clock
  input  wire logic        ref_clk,
  // core controls
  input  wire logic        core_reset,
  input  wire logic        core_power_down,
  input  wire logic [3:0]  mux_channel,
  input  wire logic        mux_internal_ref,
  // analog levels
  input  wire logic [11:0] ain [12],
  // raw result
  output logic      [11:0] core_result
);
  logic [11:0] drv = 12'h000;

  // garbage toggles while no valid input is converted
  always @(posedge ref_clk) begin
    if (core_reset || core_power_down || (!mux_internal_ref && mux_channel > 4'hB)) begin
      drv <= ~drv;
    end else if (mux_internal_ref) begin
      drv <= REF_LEVEL;
    end else begin
      drv <= ain[mux_channel];
    end
  end
  assign core_result = drv;
endmodule : acr_core_model

// ---- sim/acr_top_bench.sv ----
// self-checking bench for acr_top: random conversions, pins, bus errors
// assumes acr_top with twelve inputs and a short conversion count
`timescale 1ns/1ns
`define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin miscompares++; $display("BAD %0t %s", $time, m); end end
module acr_top_bench;
  localparam int          CONV = 2;
  localparam logic [11:0] REFV = 12'h5D2;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, core_reset, core_power_down, core_clk_tick, mux_internal_ref;
  logic        bandgap_en, ext_ref_sel, irq;
  logic [3:0]  mux_channel;
  logic [11:0] core_result, pin_analog_en, pin_digital_en, pin_pullup_en;
  logic [11:0] pin_pullup_req = 12'h000;
  logic [11:0] ain [12];
  int          miscompares = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          last_tick = 0;
  int          tick_cnt = 0;
  int          tick_gap = 0;

  acr_top #(.NUM_CHANNELS(12), .CONV_CYCLES(CONV)) i_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_result(core_result), .core_reset(core_reset), .core_power_down(core_power_down),
    .core_clk_tick(core_clk_tick), .mux_channel(mux_channel), .mux_internal_ref(mux_internal_ref),
    .bandgap_en(bandgap_en), .ext_ref_sel(ext_ref_sel),
    .pin_pullup_req(pin_pullup_req), .pin_analog_en(pin_analog_en),
    .pin_digital_en(pin_digital_en), .pin_pullup_en(pin_pullup_en), .irq(irq));

  logic [31:0] prdata8;
  logic [11:0] pin_analog_en8;
  logic [3:0]  mux_channel8;

  // eight-input variant on the same bus: channel bit three stays zero; high pins stay zero except in the first cycle after reset
  acr_top #(.NUM_CHANNELS(8), .CONV_CYCLES(CONV)) i_dut8 (
    .ref_clk(ref_clk), .reset_n(reset_n), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata8), .pready(), .pslverr(),
    .core_result(core_result), .core_reset(), .core_power_down(),
    .core_clk_tick(), .mux_channel(mux_channel8), .mux_internal_ref(),
    .bandgap_en(), .ext_ref_sel(),
    .pin_pullup_req(pin_pullup_req), .pin_analog_en(pin_analog_en8),
    .pin_digital_en(), .pin_pullup_en(), .irq());

  acr_core_model #(.REF_LEVEL(REFV)) i_core (
    .ref_clk(ref_clk), .core_reset(core_reset), .core_power_down(core_power_down),
    .mux_channel(mux_channel), .mux_internal_ref(mux_internal_ref), .ain(ain),
    .core_result(core_result));

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  // converter clock tick counter and spacing
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (core_clk_tick === 1'b1) begin
      tick_cnt  <= tick_cnt + 1;
      tick_gap  <= cyc - last_tick;
      last_tick <= cyc;
    end
  end

  // ****************
  // bus tasks
  // ****************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  logic [31:0] r;
  logic        e;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0, r, e);
  endtask : rd

  function automatic logic [15:0] fmt(input logic [11:0] v, input logic j);
    return j ? {4'h0, v} : {v, 4'h0};
  endfunction : fmt

  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    #5_000_000;
    miscompares++;
    $display("BAD %0t watchdog expired", $time);
    finish_test();
  end

  // ****************
  // tests
  // ****************
  logic [3:0]  ch, code;
  logic        j, iref, msk, xr;
  logic [11:0] en, req, expv;
  logic [7:0]  hi8;
  logic [15:0] f;
  int          base;
  initial begin
    foreach (ain[k]) ain[k] = 12'h000;
    void'($urandom(32'h3181b8bf));
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(acr_pkg::OFS_CTRL_MAIN);
    `CHK(r, 32'h60, "main reset value")
    `CHK(core_power_down, 1'b1, "powered down after reset")
    rd(acr_pkg::OFS_CTRL_AUX);
    `CHK(r, 32'h0, "aux reset value")
    rd(acr_pkg::OFS_PIN_LOW);
    `CHK(r, 32'hFF, "pin low reset")
    rd(acr_pkg::OFS_PIN_HIGH);
    `CHK(r, 32'h0F, "pin high reset")
    `CHK(pin_analog_en, 12'hFFF, "pins analog after reset")
    `CHK(irq, 1'b0, "irq after reset")
    $display("test reset done");
    for (int i = 0; i < 20; i++) begin
      ch = 4'($urandom_range(11, 0));
      code = 4'($urandom_range(7, 0));
      j = 1'($urandom_range(1, 0));
      iref = ($urandom_range(3, 0) == 0);
      msk = 1'($urandom_range(1, 0));
      xr = 1'($urandom_range(1, 0));
      foreach (ain[k]) ain[k] <= (i == 0) ? 12'hFFF : (i == 1) ? 12'h000 : 12'($urandom_range(4095, 0));
      wr(acr_pkg::OFS_IRQ_MASK, {31'h0, msk});
      wr(acr_pkg::OFS_CTRL_AUX, {24'h0, iref, iref, 1'b1, xr, 1'b1, code[2:0]});
      rd(acr_pkg::OFS_CTRL_AUX);
      `CHK(r, {24'h0, iref, iref, 1'b0, xr, 1'b0, code[2:0]}, "aux readback")
      wr(acr_pkg::OFS_CTRL_MAIN, {24'h0, 3'b100, j, ch});
      @(posedge ref_clk);
      #1;
      `CHK(core_reset, 1'b1, "core held in reset")
      rd(acr_pkg::OFS_CTRL_MAIN);
      `CHK(r, {24'h0, 3'b110, j, ch}, "busy forced by start")
      `CHK(prdata8, {24'h0, 3'b110, j, 1'b0, ch[2:0]}, "eight-input bit three reads zero")
      `CHK(mux_channel8, {1'b0, ch[2:0]}, "eight-input channel")
      `CHK(mux_channel, ch, "channel routed")
      `CHK(mux_internal_ref, iref, "reference routed")
      `CHK(bandgap_en, iref, "bandgap enable routed")
      `CHK(ext_ref_sel, xr, "reference pin select routed")
      `CHK(core_power_down, 1'b0, "core powered")
      base = tick_cnt;
      wr(acr_pkg::OFS_CTRL_MAIN, {24'h0, 3'b000, j, ch});
      for (int n = 0; n < 100; n++) begin
        rd(acr_pkg::OFS_CTRL_MAIN);
        if (r[6] === 1'b0) break;
      end
      `CHK(r, {24'h0, 3'b000, j, ch}, "busy cleared")
      `CHK(tick_cnt - base, CONV, "converter clock count")
      `CHK(tick_gap, 1 << ((code == 7) ? 6 : code), "converter clock spacing")
      `CHK(irq, msk, "irq follows mask")
      expv = iref ? REFV : ain[ch];
      f = fmt(expv, j);
      rd(acr_pkg::OFS_RES_HIGH);
      `CHK(r, {24'h0, f[15:8]}, "result high")
      rd(acr_pkg::OFS_RES_LOW);
      `CHK(r, {24'h0, f[7:0]}, "result low")
      rd(acr_pkg::OFS_IRQ_STAT);
      `CHK(r, 32'h1, "done status")
      #1;
      `CHK(irq, 1'b0, "irq cleared by read")
    end
    $display("test conversions done");
    for (int i = 0; i < 6; i++) begin
      en = 12'($urandom_range(4095, 0));
      req = 12'($urandom_range(4095, 0));
      hi8 = {4'($urandom_range(15, 0)), en[11:8]};
      wr(acr_pkg::OFS_PIN_LOW, {24'h0, en[7:0]});
      pin_pullup_req <= req;
      wr(acr_pkg::OFS_PIN_HIGH, {24'h0, hi8});
      rd(acr_pkg::OFS_PIN_HIGH);
      `CHK(r, {28'h0, en[11:8]}, "pin high readback")
      #1;
      `CHK(pin_analog_en, en, "pins routed")
      `CHK(pin_analog_en8, {4'h0, en[7:0]}, "eight-input pins")
      `CHK(pin_digital_en, ~en, "digital removed")
      `CHK(pin_pullup_en, req & ~en, "pull-ups removed")
    end
    $display("test pins done");
    rd(8'h40);
    `CHK(e, 1'b1, "unmapped error")
    `CHK(r, 32'h0, "unmapped data zero")
    wr(acr_pkg::OFS_RES_LOW, 32'hFF);
    rd(acr_pkg::OFS_RES_LOW);
    `CHK(r, {24'h0, f[7:0]}, "result read-only")
    wr(acr_pkg::OFS_CTRL_MAIN, 32'h20);
    #1;
    `CHK(core_power_down, 1'b1, "power down before sleep")
    $display("test bus done");
    finish_test();
  end
endmodule : acr_top_bench
